/* File: scsbg_pkg.sv */
package scsbg_pkg;
  localparam logic [7:0] CMC_OFF = 8'h00;
  localparam logic [7:0] TCL_OFF = 8'h04;
  localparam logic [7:0] TCH_OFF = 8'h08;
  localparam logic [7:0] MSC_OFF = 8'h0c;
  localparam logic [7:0] SIE_OFF = 8'h10;
  localparam logic [7:0] STA_OFF = 8'h14;
  localparam logic [7:0] CMC_RST = 8'h00;
  localparam logic [7:0] TC_RST = 8'h00;
  localparam logic [7:0] MSC_RST = 8'h00;
  localparam logic [7:0] SIE_RST = 8'h00;
  localparam int CMC_OSC = 7;
  localparam int CMC_RX = 5;
  localparam int CMC_TX = 3;
  localparam int CMC_PIN_OE = 2;
  localparam int CMC_PIN = 0;
  localparam int MSC_EN = 0;
  localparam int MSC_SRC = 1;
  localparam int SIE_ZC = 1;
  localparam int ST_ZC = 0;
  localparam int ST_HUNT = 1;
  localparam int ST_OSC = 2;
  localparam int ST_PIN_OE = 3;
  localparam int ST_RUN = 4;
  localparam logic [1:0] SRC_EXT = 2'h0;
  localparam logic [1:0] SRC_PIN = 2'h1;
  localparam logic [1:0] SRC_GEN = 2'h2;
  localparam logic [1:0] SRC_LOOP = 2'h3;
  localparam logic [1:0] OUT_OSC = 2'h0;
  localparam logic [1:0] OUT_TX = 2'h1;
  localparam logic [1:0] OUT_GEN = 2'h2;
  localparam logic [1:0] OUT_LOOP = 2'h3;
  localparam logic [15:0] CNT_ZERO = 16'h0000;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  typedef struct packed {
    logic [15:0] tc;
    logic en;
  } scsbg_gen_cfg_t;
  typedef struct packed {
    logic run;
    logic zero;
    logic out;
  } scsbg_gen_st_t;
  typedef enum logic [2:0] {
    GS_OFF, GS_SYNC1, GS_SYNC2, GS_RELOAD, GS_COUNT
  } scsbg_gen_state_t;
endpackage : scsbg_pkg

/* File: scsbg_baud_gen.sv */
`timescale 1ns/1ps
module scsbg_baud_gen (
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input scsbg_pkg::scsbg_gen_cfg_t cfg,
  output scsbg_pkg::scsbg_gen_st_t st
);
  scsbg_pkg::scsbg_gen_state_t state_r;
  scsbg_pkg::scsbg_gen_state_t state_nxt;
  logic [15:0] cnt_r;
  logic [15:0] cnt_nxt;
  logic out_r;
  logic out_nxt;
  wire cnt_zero = (cnt_r == scsbg_pkg::CNT_ZERO);

  // Enable is sampled every mclk so a clear acts at once
  always_comb
  begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    out_nxt = out_r;
    if (!cfg.en)
      state_nxt = scsbg_pkg::GS_OFF;
    else if (tick)
    begin
      case (state_r)
        scsbg_pkg::GS_OFF: state_nxt = scsbg_pkg::GS_SYNC1;
        scsbg_pkg::GS_SYNC1: state_nxt = scsbg_pkg::GS_SYNC2;
        scsbg_pkg::GS_SYNC2:
        begin
          out_nxt = 1'b1;
          state_nxt = scsbg_pkg::GS_RELOAD;
        end
        scsbg_pkg::GS_RELOAD:
        begin
          // Load tick plus zero tick give the +2 of the rate
          cnt_nxt = cfg.tc;
          state_nxt = scsbg_pkg::GS_COUNT;
        end
        scsbg_pkg::GS_COUNT:
        begin
          if (cnt_zero)
          begin
            out_nxt = !out_r;
            state_nxt = scsbg_pkg::GS_RELOAD;
          end
          else
            cnt_nxt = cnt_r - scsbg_pkg::CNT_ONE;
        end
        default: state_nxt = scsbg_pkg::GS_OFF;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= scsbg_pkg::GS_OFF;
      cnt_r <= scsbg_pkg::CNT_ZERO;
      out_r <= 1'b1;
    end
    else
    begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      out_r <= out_nxt;
    end
  end

  wire running = (state_r == scsbg_pkg::GS_RELOAD) ||
    (state_r == scsbg_pkg::GS_COUNT);
  assign st.run = running;
  assign st.zero = (state_r == scsbg_pkg::GS_COUNT) && cnt_zero;
  assign st.out = out_r;

  property p_start_high;
    @(posedge mclk) disable iff (rst)
    (cfg.en && tick && state_r == scsbg_pkg::GS_SYNC2) |=>
      (out_r && state_r == scsbg_pkg::GS_RELOAD);
  endproperty
  a_start_high: assert property (p_start_high)
    else $error("Generator did not start high");

  property p_zero_toggle;
    @(posedge mclk) disable iff (rst)
    (cfg.en && tick && st.zero) |=> (out_r != $past(out_r));
  endproperty
  a_zero_toggle: assert property (p_zero_toggle)
    else $error("Output did not toggle at zero count");

  property p_stop_now;
    @(posedge mclk) disable iff (rst)
    !cfg.en |=> (state_r == scsbg_pkg::GS_OFF);
  endproperty
  a_stop_now: assert property (p_stop_now)
    else $error("Generator kept running after disable");

  property p_sync_delay;
    @(posedge mclk) disable iff (rst)
    (state_r == scsbg_pkg::GS_OFF && cfg.en && tick) |=>
      !running;
  endproperty
  a_sync_delay: assert property (p_sync_delay)
    else $error("Generator started without sync delay");
endmodule : scsbg_baud_gen

/* File: scsbg_top.sv */
// Chosen here: register access over APB and the register addresses.
`timescale 1ns/1ps
module scsbg_top (
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic ext_clock_pin_in,
  input wire logic xtal_osc_in,
  output logic xtal_amp_en,
  input wire logic sync_pin_in,
  output logic sync_pin_out,
  output logic sync_pin_oe,
  input wire logic async_mode,
  input wire logic sync_pulse_req,
  input wire logic ext_sync_req,
  output logic ext_sync_active,
  output logic sync_hunt,
  input wire logic bidir_clock_pin_in,
  output logic bidir_clock_pin_out,
  output logic bidir_clock_pin_oe,
  input wire logic loop_tx_clk,
  input wire logic loop_rx_clk,
  output logic rx_clk,
  output logic tx_clk,
  output logic baud_out,
  output logic zero_count,
  output logic zero_count_status
);
  localparam int NREG = 6;

  function automatic logic [NREG-1:0] reg_dec(input logic [7:0] a);
    reg_dec = {a == scsbg_pkg::STA_OFF, a == scsbg_pkg::SIE_OFF,
      a == scsbg_pkg::MSC_OFF, a == scsbg_pkg::TCH_OFF,
      a == scsbg_pkg::TCL_OFF, a == scsbg_pkg::CMC_OFF};
  endfunction : reg_dec

  function automatic logic clk_mux(input logic [1:0] s,
    input logic ext, input logic pin, input logic gen,
    input logic lp);
    case (s)
      scsbg_pkg::SRC_EXT: clk_mux = ext;
      scsbg_pkg::SRC_PIN: clk_mux = pin;
      scsbg_pkg::SRC_GEN: clk_mux = gen;
      default: clk_mux = lp;
    endcase
  endfunction : clk_mux

  logic [7:0] cmc_r;
  logic [7:0] tcl_r;
  logic [7:0] tch_r;
  logic [7:0] msc_r;
  logic [7:0] sie_r;
  logic [31:0] prdata_r;
  logic rx_clk_r;
  logic tx_clk_r;
  logic pin_out_r;
  logic pin_oe_r;
  logic sync_oe_r;
  logic hunt_r;
  logic ext_sync_r;
  logic gen_src_prev_r;
  scsbg_pkg::scsbg_gen_cfg_t gen_cfg;
  scsbg_pkg::scsbg_gen_st_t gen_st;

  // APB decode: zero wait states, error on unmapped offsets
  wire [NREG-1:0] sel = reg_dec(paddr);
  wire hit = |sel;
  wire access = psel && penable;
  wire wr = access && pwrite && hit;
  wire [NREG-1:0] wsel = sel & {NREG{wr}};

  assign pready = 1'b1;
  assign pslverr = access && !hit;
  assign prdata = prdata_r;

  wire osc_en = cmc_r[scsbg_pkg::CMC_OSC];
  wire [1:0] rx_sel = cmc_r[scsbg_pkg::CMC_RX +: 2];
  wire [1:0] tx_sel = cmc_r[scsbg_pkg::CMC_TX +: 2];
  wire [1:0] pin_sel = cmc_r[scsbg_pkg::CMC_PIN +: 2];
  wire pin_req = cmc_r[scsbg_pkg::CMC_PIN_OE];

  // Crystal output stands in for the external pin wherever chosen
  wire ext_src = osc_en ? xtal_osc_in : ext_clock_pin_in;

  wire rx_nxt = clk_mux(rx_sel, ext_src, bidir_clock_pin_in,
    gen_st.out, loop_tx_clk);
  wire tx_nxt = clk_mux(tx_sel, ext_src, bidir_clock_pin_in,
    gen_st.out, loop_tx_clk);

  // A pin used as an input by either clock may never be driven
  wire pin_oe_nxt = pin_req && (rx_sel != scsbg_pkg::SRC_PIN) &&
    (tx_sel != scsbg_pkg::SRC_PIN);

  logic pin_out_nxt;
  always_comb
  begin
    case (pin_sel)
      scsbg_pkg::OUT_OSC: pin_out_nxt = osc_en ? xtal_osc_in : 1'b1;
      scsbg_pkg::OUT_TX: pin_out_nxt = tx_nxt;
      scsbg_pkg::OUT_GEN: pin_out_nxt = gen_st.out;
      default: pin_out_nxt = loop_rx_clk;
    endcase
  end

  // While the crystal runs the sync pin is not driven or used for external sync; hunt ignores it in async mode only
  wire sync_oe_nxt = !osc_en && !async_mode && !ext_sync_req &&
    sync_pulse_req;
  wire ext_sync_nxt = ext_sync_req && !osc_en;
  wire hunt_nxt = (osc_en && async_mode) ? 1'b0 : !sync_pin_in;

  // Generator clock: pin or crystal edges, or every bus clock
  wire gen_src_sel = msc_r[scsbg_pkg::MSC_SRC];
  wire gen_tick = gen_src_sel ? 1'b1 :
    (ext_src && !gen_src_prev_r);

  assign gen_cfg.tc = {tch_r, tcl_r};
  assign gen_cfg.en = msc_r[scsbg_pkg::MSC_EN];

  scsbg_baud_gen u_gen (
    .mclk(mclk),
    .rst(rst),
    .tick(gen_tick),
    .cfg(gen_cfg),
    .st(gen_st)
  );

  wire zc_ie = sie_r[scsbg_pkg::SIE_ZC];

  logic [31:0] status;
  always_comb
  begin
    status = 32'h0000_0000;
    status[scsbg_pkg::ST_ZC] = gen_st.zero && zc_ie;
    status[scsbg_pkg::ST_HUNT] = hunt_r;
    status[scsbg_pkg::ST_OSC] = osc_en;
    status[scsbg_pkg::ST_PIN_OE] = pin_oe_r;
    status[scsbg_pkg::ST_RUN] = gen_st.run;
  end

  wire [31:0] rd_mux =
    ({32{sel[0]}} & {24'h00_0000, cmc_r}) |
    ({32{sel[1]}} & {24'h00_0000, tcl_r}) |
    ({32{sel[2]}} & {24'h00_0000, tch_r}) |
    ({32{sel[3]}} & {24'h00_0000, msc_r}) |
    ({32{sel[4]}} & {24'h00_0000, sie_r}) |
    ({32{sel[5]}} & status);

  // Reset value of misc control selects the pin and stops the counter
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cmc_r <= scsbg_pkg::CMC_RST;
      tcl_r <= scsbg_pkg::TC_RST;
      tch_r <= scsbg_pkg::TC_RST;
      msc_r <= scsbg_pkg::MSC_RST;
      sie_r <= scsbg_pkg::SIE_RST;
    end
    else
    begin
      if (wsel[0])
        cmc_r <= pwdata[7:0];
      if (wsel[1])
        tcl_r <= pwdata[7:0];
      if (wsel[2])
        tch_r <= pwdata[7:0];
      if (wsel[3])
        msc_r <= pwdata[7:0];
      if (wsel[4])
        sie_r <= pwdata[7:0];
    end
  end

  // Read data is captured in the setup cycle so it stands in access
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata_r <= 32'h0000_0000;
    else if (psel && !penable)
      prdata_r <= rd_mux;
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      rx_clk_r <= 1'b0;
      tx_clk_r <= 1'b0;
      pin_out_r <= 1'b1;
      pin_oe_r <= 1'b0;
      sync_oe_r <= 1'b0;
      hunt_r <= 1'b0;
      ext_sync_r <= 1'b0;
      gen_src_prev_r <= 1'b0;
    end
    else
    begin
      rx_clk_r <= rx_nxt;
      tx_clk_r <= tx_nxt;
      pin_out_r <= pin_out_nxt;
      pin_oe_r <= pin_oe_nxt;
      sync_oe_r <= sync_oe_nxt;
      hunt_r <= hunt_nxt;
      ext_sync_r <= ext_sync_nxt;
      gen_src_prev_r <= ext_src;
    end
  end

  assign xtal_amp_en = osc_en;
  assign sync_pin_out = 1'b0;
  assign sync_pin_oe = sync_oe_r;
  assign ext_sync_active = ext_sync_r;
  assign sync_hunt = hunt_r;
  assign bidir_clock_pin_out = pin_out_r;
  assign bidir_clock_pin_oe = pin_oe_r;
  assign rx_clk = rx_clk_r;
  assign tx_clk = tx_clk_r;
  assign baud_out = gen_st.out;
  assign zero_count = gen_st.zero;
  // Status only reports zero count while its enable is set
  assign zero_count_status = gen_st.zero && zc_ie;

  property p_osc_write;
    @(posedge mclk) disable iff (rst)
    wsel[0] |=> (xtal_amp_en == $past(pwdata[scsbg_pkg::CMC_OSC]));
  endproperty
  a_osc_write: assert property (p_osc_write)
    else $error("Crystal enable did not follow write");

  property p_rx_xtal;
    @(posedge mclk) disable iff (rst)
    (osc_en && rx_sel == scsbg_pkg::SRC_EXT && !wsel[0]) |=>
      (rx_clk == $past(xtal_osc_in));
  endproperty
  a_rx_xtal: assert property (p_rx_xtal)
    else $error("Receive clock not from crystal");

  property p_no_sync;
    @(posedge mclk) disable iff (rst)
    osc_en |=> (!sync_pin_oe && !ext_sync_active);
  endproperty
  a_no_sync: assert property (p_no_sync)
    else $error("Sync pin used while crystal on");

  property p_hunt_zero;
    @(posedge mclk) disable iff (rst)
    (osc_en && async_mode) |=> !sync_hunt;
  endproperty
  a_hunt_zero: assert property (p_hunt_zero)
    else $error("Sync/hunt not forced low");

  property p_rx_gen;
    @(posedge mclk) disable iff (rst)
    (rx_sel == scsbg_pkg::SRC_GEN && !wsel[0]) |=>
      (rx_clk == $past(baud_out));
  endproperty
  a_rx_gen: assert property (p_rx_gen)
    else $error("Receive clock not from generator");

  property p_tx_loop;
    @(posedge mclk) disable iff (rst)
    (tx_sel == scsbg_pkg::SRC_LOOP && !wsel[0]) |=>
      (tx_clk == $past(loop_tx_clk));
  endproperty
  a_tx_loop: assert property (p_tx_loop)
    else $error("Transmit clock not from loop");

  property p_pin_input;
    @(posedge mclk) disable iff (rst)
    (rx_sel == scsbg_pkg::SRC_PIN || tx_sel == scsbg_pkg::SRC_PIN ||
      !pin_req) |=> !bidir_clock_pin_oe;
  endproperty
  a_pin_input: assert property (p_pin_input)
    else $error("Bidir pin driven while in use");

  property p_pin_high;
    @(posedge mclk) disable iff (rst)
    (pin_sel == scsbg_pkg::OUT_OSC && !osc_en) |=>
      bidir_clock_pin_out;
  endproperty
  a_pin_high: assert property (p_pin_high)
    else $error("Bidir pin not high with crystal off");

  property p_pin_gen;
    @(posedge mclk) disable iff (rst)
    (pin_sel == scsbg_pkg::OUT_GEN) |=>
      (bidir_clock_pin_out == $past(baud_out));
  endproperty
  a_pin_gen: assert property (p_pin_gen)
    else $error("Bidir pin not showing generator");

  property p_zc_gate;
    @(posedge mclk) disable iff (rst)
    zero_count_status |-> (zero_count && zc_ie);
  endproperty
  a_zc_gate: assert property (p_zc_gate)
    else $error("Zero count status without cause");

  property p_tx_xtal;
    @(posedge mclk) disable iff (rst)
    (osc_en && tx_sel == scsbg_pkg::SRC_EXT && !wsel[0]) |=>
      (tx_clk == $past(xtal_osc_in));
  endproperty
  a_tx_xtal: assert property (p_tx_xtal)
    else $error("Transmit clock not from crystal");

  property p_rx_ext;
    @(posedge mclk) disable iff (rst)
    (!osc_en && rx_sel == scsbg_pkg::SRC_EXT && !wsel[0]) |=>
      (rx_clk == $past(ext_clock_pin_in));
  endproperty
  a_rx_ext: assert property (p_rx_ext)
    else $error("Receive clock not from external pin");

  property p_pin_loop;
    @(posedge mclk) disable iff (rst)
    (pin_sel == scsbg_pkg::OUT_LOOP) |=>
      (bidir_clock_pin_out == $past(loop_rx_clk));
  endproperty
  a_pin_loop: assert property (p_pin_loop)
    else $error("Bidir pin not showing loop receive clock");

  property p_pin_drive;
    @(posedge mclk) disable iff (rst)
    (pin_req && rx_sel != scsbg_pkg::SRC_PIN &&
      tx_sel != scsbg_pkg::SRC_PIN) |=> bidir_clock_pin_oe;
  endproperty
  a_pin_drive: assert property (p_pin_drive)
    else $error("Bidir pin not driven when free");

  property p_hunt_pin;
    @(posedge mclk) disable iff (rst)
    !(osc_en && async_mode) |=>
      (sync_hunt == !$past(sync_pin_in));
  endproperty
  a_hunt_pin: assert property (p_hunt_pin)
    else $error("Sync/hunt not following sync pin");

  property p_wr_tc;
    @(posedge mclk) disable iff (rst)
    wsel[1] |=> (gen_cfg.tc[7:0] == $past(pwdata[7:0]));
  endproperty
  a_wr_tc: assert property (p_wr_tc)
    else $error("Low constant byte did not follow write");
endmodule : scsbg_top

/* File: scsbg_clk_src.sv */
`timescale 1ns/1ps
module scsbg_clk_src (
  input wire logic mclk,
  input wire logic rst,
  input wire logic pin_oe,
  input wire logic pin_drv,
  output logic ext_clk,
  output logic xtal,
  output logic pin_lvl,
  output logic loop_tx,
  output logic loop_rx
);
  logic [7:0] cnt_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      cnt_r <= 8'h00;
    else
      cnt_r <= cnt_r + 8'h01;
  end
  // Crystal is stable at once, so no settling wait is modelled
  assign xtal = cnt_r[1];
  assign ext_clk = cnt_r[2];
  assign loop_tx = cnt_r[0] ^ cnt_r[3];
  assign loop_rx = cnt_r[1] ^ cnt_r[4];
  // Far end lets go while the device drives the shared clock wire
  assign pin_lvl = pin_oe ? pin_drv : (cnt_r[0] ^ cnt_r[2]);
endmodule : scsbg_clk_src

/* File: testbench.sv */
`timescale 1ns/1ps
module testbench;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic async_mode = 1'b0;
  logic pulse_req = 1'b0;
  logic esync_req = 1'b0;
  logic sync_in = 1'b1;
  logic osc_on = 1'b0;
  logic ie = 1'b0;
  logic [31:0] prdata, q;
  logic pready, pslverr, e, ext, xtal, pin_lvl, ltx, lrx, amp;
  logic s_out, s_oe, esa, hunt, p_out, p_oe, rxc, txc, bo, zc, zcs;
  int err_count = 0;
  int check_count = 0;
  int cyc = 0;
  int zm = 0;
  always #20 mclk = ~mclk;
  scsbg_top i_scsbg_top (.mclk(mclk), .rst(rst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .ext_clock_pin_in(ext), .xtal_osc_in(xtal), .xtal_amp_en(amp),
    .sync_pin_in(sync_in), .sync_pin_out(s_out), .sync_pin_oe(s_oe),
    .async_mode(async_mode), .sync_pulse_req(pulse_req),
    .ext_sync_req(esync_req), .ext_sync_active(esa), .sync_hunt(hunt),
    .bidir_clock_pin_in(pin_lvl), .bidir_clock_pin_out(p_out),
    .bidir_clock_pin_oe(p_oe), .loop_tx_clk(ltx), .loop_rx_clk(lrx),
    .rx_clk(rxc), .tx_clk(txc), .baud_out(bo), .zero_count(zc),
    .zero_count_status(zcs));
  scsbg_clk_src i_scsbg_clk_src (.mclk(mclk), .rst(rst), .pin_oe(p_oe),
    .pin_drv(p_out), .ext_clk(ext), .xtal(xtal), .pin_lvl(pin_lvl),
    .loop_tx(ltx), .loop_rx(lrx));

  task automatic give_verdict;
    if (err_count == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : give_verdict

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  task automatic apb(input logic wr, input logic [7:0] a,
      input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask : rdchk

  function automatic logic srcv(input logic [1:0] s);
    case (s)
      scsbg_pkg::SRC_EXT: return osc_on ? xtal : ext;
      scsbg_pkg::SRC_PIN: return pin_lvl;
      scsbg_pkg::SRC_GEN: return bo;
      default: return ltx;
    endcase
  endfunction : srcv

  // Caller must be settled after an edge; counts edges until baud_out moves
  task automatic half(output int n, output int z);
    logic b;
    b = bo;
    n = 0;
    z = 0;
    while (bo === b && n < 1000)
    begin
      @(posedge mclk);
      #1;
      n++;
      z += int'(zc === 1'b1);
      zm += int'(zcs !== (zc & ie));
    end
  endtask : half

  task automatic t_regs;
    for (int i = 0; i < 6; i++)
      rdchk(8'(4 * i), 32'h0);
    apb(1'b1, scsbg_pkg::TCL_OFF, 32'hffffff5a);
    rdchk(scsbg_pkg::TCL_OFF, 32'h5a);
    apb(1'b1, 8'h18, 32'hff);
    chk(32'(e), 32'h1);
    rdchk(8'h18, 32'h0);
  endtask : t_regs

  task automatic t_mux;
    logic [1:0] r, t;
    logic er, et;
    for (int i = 0; i < 8; i++)
    begin
      r = i[1:0];
      t = r + 2'h1;
      osc_on = i[2];
      apb(1'b1, scsbg_pkg::CMC_OFF, {24'h0, osc_on, r, t, 3'h0});
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(amp), 32'(osc_on));
      repeat (16)
      begin
        er = srcv(r);
        et = srcv(t);
        @(posedge mclk);
        #1;
        chk(32'({rxc, txc}), 32'({er, et}));
      end
    end
  endtask : t_mux

  task automatic t_pin;
    logic ev;
    for (int i = 0; i < 5; i++)
    begin
      osc_on = (i == 4);
      apb(1'b1, scsbg_pkg::CMC_OFF,
        {24'h0, osc_on, 2'h0, 2'h2, 1'b1, i[1:0]});
      repeat (2) @(posedge mclk);
      #1;
      chk(32'(p_oe), 32'h1);
      repeat (12)
      begin
        case (i[1:0])
          2'h0: ev = osc_on ? xtal : 1'b1;
          2'h3: ev = lrx;
          default: ev = bo;
        endcase
        @(posedge mclk);
        #1;
        chk(32'(p_out), 32'(ev));
      end
    end
    // Both clocks take the pin, so it must stay an input
    apb(1'b1, scsbg_pkg::CMC_OFF, 32'h2c);
    repeat (2) @(posedge mclk);
    #1;
    chk(32'(p_oe), 32'h0);
  endtask : t_pin

  task automatic t_sync;
    @(posedge mclk);
    pulse_req <= 1'b1;
    sync_in <= 1'b0;
    // Bit 0 of i turns the crystal on, bit 1 asks for external sync
    for (int i = 0; i < 4; i++)
    begin
      apb(1'b1, scsbg_pkg::CMC_OFF, i[0] ? 32'h80 : 32'h0);
      async_mode <= 1'b0;
      esync_req <= i[1];
      repeat (3) @(posedge mclk);
      #1;
      chk(32'({s_oe, esa, s_out}),
        (i == 0) ? 32'h4 : (i == 2) ? 32'h2 : 32'h0);
      @(posedge mclk);
      async_mode <= 1'b1;
      repeat (3) @(posedge mclk);
      #1;
      chk(32'(hunt), i[0] ? 32'h0 : 32'h1);
    end
  endtask : t_sync

  task automatic ext_run(input logic [31:0] cm, input int exp);
    int n, z;
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h0);
    apb(1'b1, scsbg_pkg::CMC_OFF, cm);
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h1);
    #1;
    repeat (3) half(n, z);
    chk(32'(n), 32'(exp));
  endtask : ext_run

  task automatic t_gen;
    int n, z;
    logic b;
    apb(1'b1, scsbg_pkg::CMC_OFF, 32'h0);
    apb(1'b1, scsbg_pkg::TCL_OFF, 32'h03);
    apb(1'b1, scsbg_pkg::TCH_OFF, 32'h00);
    apb(1'b1, scsbg_pkg::SIE_OFF, 32'h2);
    ie = 1'b1;
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h2);
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h3);
    #1;
    half(n, z);
    zm = 0;
    repeat (2)
    begin
      half(n, z);
      chk(32'(n), 32'h5);
      chk(32'(z), 32'h1);
    end
    chk(32'(zm), 32'h0);
    // Stopped with the output low so the restart must raise it
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h2);
    apb(1'b1, scsbg_pkg::SIE_OFF, 32'h0);
    ie = 1'b0;
    b = bo;
    repeat (20) @(posedge mclk);
    #1;
    chk(32'({bo, zcs}), 32'({b, 1'b0}));
    apb(1'b1, scsbg_pkg::TCL_OFF, 32'h02);
    apb(1'b1, scsbg_pkg::TCH_OFF, 32'h01);
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h3);
    n = 0;
    while (bo !== 1'b1 && n < 20)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk(32'(n), 32'h3);
    half(n, z);
    half(n, z);
    chk(32'(n), 32'd260);
    apb(1'b1, scsbg_pkg::MSC_OFF, 32'h2);
    apb(1'b1, scsbg_pkg::TCL_OFF, 32'h00);
    apb(1'b1, scsbg_pkg::TCH_OFF, 32'h00);
    ext_run(32'h00, 16);
    ext_run(32'h80, 8);
  endtask : t_gen

  always @(posedge mclk)
  begin
    cyc++;
    if (cyc == 20000)
    begin
      err_count++;
      give_verdict();
    end
  end

  initial
  begin
    repeat (2) @(posedge mclk);
    rst <= 1'b0;
    t_regs();
    t_mux();
    t_pin();
    t_sync();
    t_gen();
    give_verdict();
  end
endmodule : testbench
